//--- verilog/dhc_pkg.sv
// Constants, register map and types for the dual hysteresis comparator.
// Assumes one 40 MHz core clock and a simple strobe register port.
//
// What this block does
// (R1) Two comparators each with their own mode, on threshold and off threshold, fully independent.
// (R2) A comparator whose mode is zero is disabled and never asserts its result.
// (R3) Each nonzero unsigned mode compares its own actual quantity against its own reference.
// (R4) Some modes use a fixed reference, such as 1000 V for the DC link voltage mode.
// (R5) The speed mode derives its reference from maximum frequency and pole pairs.
// (R6) Modes 101 to 107, 111 and 112 compare the signed quantity instead of its magnitude.
// (R7) Each comparator holds separate switch-on and switch-off percentage thresholds.
// (R8) The switch-on threshold spans -300.00 % to 300.00 % and resets to 100.00 %.
// (R9) The switch-off threshold spans -300.00 % to 300.00 % and resets to 50.00 %.
// (R10) The output goes active when the quantity rises above on-percentage times reference.
// (R11) An active output clears only below off-percentage times reference, else it holds.
// (R12) Each comparator presents its result as a digital signal for other functions.
// (R13) Each comparator also drives an output that is always the inverse of its result.
// (R14) Unsigned modes take the absolute value of the quantity before comparing.
// (R15) After reset or while disabled the result is inactive and the inverse is active.
package dhc_pkg;
	localparam int unsigned N_CMP = 2;
	// register byte addresses
	localparam logic [7:0] A_MODE1 = 8'h00;
	localparam logic [7:0] A_ON1 = 8'h04;
	localparam logic [7:0] A_OFF1 = 8'h08;
	localparam logic [7:0] A_MODE2 = 8'h0C;
	localparam logic [7:0] A_ON2 = 8'h10;
	localparam logic [7:0] A_OFF2 = 8'h14;
	localparam logic [7:0] A_RATED = 8'h18;
	localparam logic [7:0] A_FMAX = 8'h1C;
	localparam logic [7:0] A_POLES = 8'h20;
	localparam logic [7:0] A_MAXREF = 8'h24;
	localparam logic [7:0] A_SPDREF = 8'h28;
	localparam logic [7:0] A_STATUS = 8'h2C;
	localparam logic [7:0] A_CLEAR = 8'h30;
	localparam logic [7:0] A_IRQEN = 8'h34;
	localparam logic [7:0] A_OUTS = 8'h38;
	// thresholds in 0.01 % steps
	localparam logic signed [15:0] PCT_FULL = 16'sh2710;
	localparam logic signed [31:0] PCT_MAX = 32'sh0000_7530;
	localparam logic signed [31:0] PCT_MIN = -32'sh0000_7530;
	localparam logic signed [15:0] ON_RST = 16'sh2710;
	localparam logic signed [15:0] OFF_RST = 16'sh1388;
	// configuration reset values, plain defaults
	localparam logic [15:0] RATED_RST = 16'h03E8;
	localparam logic [15:0] FMAX_RST = 16'h1388;
	localparam logic [7:0] POLES_RST = 8'h02;
	localparam logic [15:0] MAXREF_RST = 16'h2710;
	// fixed references
	localparam logic [15:0] TEMP_REF = 16'h0064;
	localparam logic [15:0] DC_REF = 16'h03E8;
	localparam logic [15:0] ANALOG_REF = 16'h2710;
	// speed in rpm from 0.01 Hz: fmax * 3 / (5 * poles)
	localparam logic [1:0] SPD_MUL = 2'h3;
	localparam logic [2:0] SPD_DIV = 3'h5;
	localparam logic [4:0] DV_STEPS = 5'h11;
	localparam logic [17:0] DV_NUM_RST = 18'h03A98;
	localparam logic [10:0] DV_DEN_RST = 11'h00A;
	// mode codes
	localparam logic [7:0] MODE_SIGNED_BASE = 8'h64;
	localparam logic [3:0] B_OFF = 4'h0;
	localparam logic [3:0] B_ABS_CUR = 4'h1;
	localparam logic [3:0] B_ACT_CUR = 4'h2;
	localparam logic [3:0] B_STATOR_F = 4'h3;
	localparam logic [3:0] B_SPEED = 4'h4;
	localparam logic [3:0] B_REP_F = 4'h5;
	localparam logic [3:0] B_TEMP = 4'h6;
	localparam logic [3:0] B_ACT_F = 4'h7;
	localparam logic [3:0] B_DCLINK = 4'h9;
	localparam logic [3:0] B_ISQ = 4'hA;
	localparam logic [3:0] B_FILT_CUR = 4'hB;
	localparam logic [3:0] B_INT_REF_F = 4'hC;
	localparam logic [3:0] B_REF_PCT = 4'hD;
	localparam logic [3:0] B_ACT_PCT = 4'hE;
	localparam logic [3:0] B_ANALOG = 4'hF;
	typedef struct packed {
		logic signed_cmp;
		logic [3:0] base;
	} dhc_mode_t;
endpackage

//--- verilog/dhc_ch_if.sv
// Bundle between the register core and one comparator channel.
// Assumes the core drives the request side combinationally.
`timescale 1ns/100ps
interface dhc_ch_if;
	logic en;
	logic signed_cmp;
	logic signed [15:0] actual;
	logic [15:0] ref_val;
	logic signed [15:0] on_pct;
	logic signed [15:0] off_pct;
	logic hit;
	logic rise;
	logic fall;
	modport core (output en, signed_cmp, actual, ref_val, on_pct, off_pct,
		input hit, rise, fall);
	modport cmp (input en, signed_cmp, actual, ref_val, on_pct, off_pct,
		output hit, rise, fall);
endinterface

//--- verilog/dhc_channel.sv
// One hysteresis comparator channel.
// Assumes inputs are synchronous to core_clk and a reference already selected.
`timescale 1ns/100ps
module dhc_channel
	import dhc_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	dhc_ch_if.cmp ch
);
	typedef struct packed {
		logic hit;
		logic rise;
		logic fall;
	} dhc_chst_t;

	dhc_chst_t st_q;
	dhc_chst_t st_d;
	logic signed [16:0] mag;
	logic signed [33:0] lhs;
	logic signed [33:0] on_rhs;
	logic signed [33:0] off_rhs;
	logic above_on;
	logic below_off;

	always_comb begin
		mag = ch.actual;
		if (!ch.signed_cmp && ch.actual[15]) begin
			mag = -mag; // R14
		end
		// scale both sides to 0.01 % so no divide is needed
		lhs = mag * PCT_FULL;
		on_rhs = ch.on_pct * $signed({1'b0, ch.ref_val});
		off_rhs = ch.off_pct * $signed({1'b0, ch.ref_val});
		above_on = lhs > on_rhs;
		below_off = lhs < off_rhs;
	end

	always_comb begin
		st_d = st_q;
		if (!ch.en) begin
			st_d.hit = 1'b0; // R2 R15
		end else if (above_on) begin
			st_d.hit = 1'b1; // R10
		end else if (below_off) begin
			st_d.hit = 1'b0; // R11
		end
		st_d.rise = st_d.hit & ~st_q.hit;
		st_d.fall = ~st_d.hit & st_q.hit;
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign ch.hit = st_q.hit; // R12
	assign ch.rise = st_q.rise;
	assign ch.fall = st_q.fall;

	property p_on_sets;
		@(posedge core_clk) disable iff (!arst_n)
		ch.en && above_on |=> ch.hit;
	endproperty
	a_on_sets: assert property (p_on_sets) else $error("on threshold missed"); // R10

	property p_hold_band;
		@(posedge core_clk) disable iff (!arst_n)
		ch.en && !above_on && !below_off |=> ch.hit == $past(ch.hit);
	endproperty
	a_hold_band: assert property (p_hold_band) else $error("hysteresis band not held"); // R11

	property p_off_clears;
		@(posedge core_clk) disable iff (!arst_n)
		ch.en && !above_on && below_off |=> !ch.hit;
	endproperty
	a_off_clears: assert property (p_off_clears) else $error("off threshold missed"); // R11
endmodule

//--- verilog/dhc_top.sv
// Register core and quantity selection for two hysteresis comparators.
// Assumes a strobe register port; read data valid only the cycle after a read.
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/100ps
module dhc_top
	import dhc_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic signed [15:0] rms_current,
	input wire logic signed [15:0] active_current,
	input wire logic signed [15:0] stator_freq,
	input wire logic signed [15:0] actual_speed,
	input wire logic signed [15:0] repetition_freq,
	input wire logic signed [15:0] winding_temp,
	input wire logic signed [15:0] actual_freq,
	input wire logic signed [15:0] dc_link_voltage,
	input wire logic signed [15:0] isq_current,
	input wire logic signed [15:0] filt_active_current,
	input wire logic signed [15:0] int_ref_freq,
	input wire logic signed [15:0] ref_percent,
	input wire logic signed [15:0] actual_percent,
	input wire logic signed [15:0] analog_input_one,
	output logic [1:0] cmp_out,
	output logic [1:0] cmp_out_n,
	output logic irq
);
	typedef struct packed {
		logic [1:0][7:0] mode;
		logic [1:0][15:0] on_pct;
		logic [1:0][15:0] off_pct;
		logic [15:0] rated;
		logic [15:0] fmax;
		logic [7:0] poles;
		logic [15:0] maxref;
		logic [15:0] spd_ref;
		logic dv_busy;
		logic [4:0] dv_cnt;
		logic [17:0] dv_num;
		logic [10:0] dv_den;
		logic [10:0] dv_rem;
		logic [17:0] dv_quo;
		logic [3:0] status;
		logic [3:0] irq_en;
		logic [31:0] rdata;
		logic [1:0] out;
		logic [1:0] out_n;
		logic irq;
	} dhc_state_t;

	dhc_state_t s_q;
	dhc_state_t s_d;
	dhc_mode_t dec [N_CMP];
	logic signed [15:0] sel_act [N_CMP];
	logic [15:0] sel_ref [N_CMP];
	logic [1:0] hit;
	logic [3:0] events;
	logic [11:0] rem_sh;
	logic rem_ge;

	// unknown codes fall back to off rather than to a guessed quantity
	function automatic dhc_mode_t mode_decode(input logic [7:0] m);
		dhc_mode_t r;
		logic [7:0] sb;
		r = '0;
		sb = m - MODE_SIGNED_BASE;
		if (m != 8'h00 && m <= 8'h0F && m != 8'h08) begin
			r.base = m[3:0]; // R3
		end else if ((m >= MODE_SIGNED_BASE && sb <= 8'h07) || sb == 8'h0B || sb == 8'h0C) begin
			r.signed_cmp = 1'b1; // R6
			r.base = sb[3:0];
		end
		return r;
	endfunction

	function automatic logic [15:0] pct_clamp(input logic [31:0] w);
		logic signed [31:0] v;
		v = w;
		if (v > PCT_MAX) begin
			return PCT_MAX[15:0];
		end else if (v < PCT_MIN) begin
			return PCT_MIN[15:0];
		end
		return w[15:0];
	endfunction

	dhc_ch_if ch [N_CMP] ();

	generate
		for (genvar g = 0; g < N_CMP; g++) begin : g_cmp
			always_comb begin
				dec[g] = mode_decode(s_q.mode[g]);
				sel_act[g] = '0;
				sel_ref[g] = '0;
				unique case (dec[g].base)
					B_ABS_CUR: begin
						sel_act[g] = rms_current;
						sel_ref[g] = s_q.rated;
					end
					B_ACT_CUR: begin
						sel_act[g] = active_current;
						sel_ref[g] = s_q.rated;
					end
					B_STATOR_F: begin
						sel_act[g] = stator_freq;
						sel_ref[g] = s_q.fmax;
					end
					B_SPEED: begin
						sel_act[g] = actual_speed;
						sel_ref[g] = s_q.spd_ref; // R5
					end
					B_REP_F: begin
						sel_act[g] = repetition_freq;
						sel_ref[g] = s_q.fmax;
					end
					B_TEMP: begin
						sel_act[g] = winding_temp;
						sel_ref[g] = TEMP_REF; // R4
					end
					B_ACT_F: begin
						sel_act[g] = actual_freq;
						sel_ref[g] = s_q.fmax;
					end
					B_DCLINK: begin
						sel_act[g] = dc_link_voltage;
						sel_ref[g] = DC_REF; // R4
					end
					B_ISQ: begin
						sel_act[g] = isq_current;
						sel_ref[g] = s_q.rated;
					end
					B_FILT_CUR: begin
						sel_act[g] = filt_active_current;
						sel_ref[g] = s_q.rated;
					end
					B_INT_REF_F: begin
						sel_act[g] = int_ref_freq;
						sel_ref[g] = s_q.fmax;
					end
					B_REF_PCT: begin
						sel_act[g] = ref_percent;
						sel_ref[g] = s_q.maxref;
					end
					B_ACT_PCT: begin
						sel_act[g] = actual_percent;
						sel_ref[g] = s_q.maxref; // R3
					end
					B_ANALOG: begin
						sel_act[g] = analog_input_one;
						sel_ref[g] = ANALOG_REF;
					end
					default: begin
						sel_act[g] = '0;
						sel_ref[g] = '0;
					end
				endcase
			end
			assign ch[g].en = dec[g].base != B_OFF; // R2
			assign ch[g].signed_cmp = dec[g].signed_cmp; // R6
			assign ch[g].actual = sel_act[g];
			assign ch[g].ref_val = sel_ref[g];
			assign ch[g].on_pct = s_q.on_pct[g]; // R7
			assign ch[g].off_pct = s_q.off_pct[g]; // R7
			assign hit[g] = ch[g].hit;
			assign events[2 * g] = ch[g].rise;
			assign events[2 * g + 1] = ch[g].fall;
			// each channel sees only its own mode and thresholds
			dhc_channel dhc_channel_i (
				.core_clk(core_clk),
				.arst_n(arst_n),
				.ch(ch[g])
			); // R1
		end
	endgenerate

	always_comb begin
		s_d = s_q;
		rem_sh = {s_q.dv_rem, s_q.dv_num[17]};
		rem_ge = rem_sh >= {1'b0, s_q.dv_den};
		// restoring divide, one quotient bit per cycle; speed ref lags a write by 18 cycles
		if (s_q.dv_busy) begin
			s_d.dv_rem = rem_ge ? 11'(rem_sh - {1'b0, s_q.dv_den}) : rem_sh[10:0];
			s_d.dv_num = {s_q.dv_num[16:0], 1'b0};
			s_d.dv_quo = {s_q.dv_quo[16:0], rem_ge};
			s_d.dv_cnt = s_q.dv_cnt - 5'h01;
			if (s_q.dv_cnt == 5'h00) begin
				s_d.dv_busy = 1'b0;
				s_d.spd_ref = s_d.dv_quo[15:0]; // R5
			end
		end
		if (reg_wr) begin
			unique case (reg_addr)
				A_MODE1: s_d.mode[0] = reg_wdata[7:0]; // R1
				A_ON1: s_d.on_pct[0] = pct_clamp(reg_wdata); // R8
				A_OFF1: s_d.off_pct[0] = pct_clamp(reg_wdata); // R9
				A_MODE2: s_d.mode[1] = reg_wdata[7:0]; // R1
				A_ON2: s_d.on_pct[1] = pct_clamp(reg_wdata); // R8
				A_OFF2: s_d.off_pct[1] = pct_clamp(reg_wdata); // R9
				A_RATED: s_d.rated = reg_wdata[15:0];
				A_FMAX: s_d.fmax = reg_wdata[15:0];
				// zero pole pairs would divide by zero
				A_POLES: s_d.poles = (reg_wdata[7:0] == 8'h00) ? 8'h01 : reg_wdata[7:0];
				A_MAXREF: s_d.maxref = reg_wdata[15:0];
				A_IRQEN: s_d.irq_en = reg_wdata[3:0];
				default: begin
				end
			endcase
			if (reg_addr == A_FMAX || reg_addr == A_POLES) begin
				s_d.dv_busy = 1'b1;
				s_d.dv_cnt = DV_STEPS;
				s_d.dv_num = 18'(s_d.fmax * SPD_MUL);
				s_d.dv_den = 11'(s_d.poles * SPD_DIV);
				s_d.dv_rem = '0;
				s_d.dv_quo = '0;
			end
		end
		// a new event beats a clear in the same cycle
		s_d.status = s_q.status;
		if (reg_wr && reg_addr == A_CLEAR) begin
			s_d.status = s_q.status & ~reg_wdata[3:0];
		end
		s_d.status = s_d.status | events;
		s_d.rdata = '0;
		if (reg_rd) begin
			unique case (reg_addr)
				A_MODE1: s_d.rdata = {24'h000000, s_q.mode[0]};
				A_ON1: s_d.rdata = {{16{s_q.on_pct[0][15]}}, s_q.on_pct[0]};
				A_OFF1: s_d.rdata = {{16{s_q.off_pct[0][15]}}, s_q.off_pct[0]};
				A_MODE2: s_d.rdata = {24'h000000, s_q.mode[1]};
				A_ON2: s_d.rdata = {{16{s_q.on_pct[1][15]}}, s_q.on_pct[1]};
				A_OFF2: s_d.rdata = {{16{s_q.off_pct[1][15]}}, s_q.off_pct[1]};
				A_RATED: s_d.rdata = {16'h0000, s_q.rated};
				A_FMAX: s_d.rdata = {16'h0000, s_q.fmax};
				A_POLES: s_d.rdata = {24'h000000, s_q.poles};
				A_MAXREF: s_d.rdata = {16'h0000, s_q.maxref};
				A_SPDREF: s_d.rdata = {15'h0000, s_q.dv_busy, s_q.spd_ref};
				A_STATUS: s_d.rdata = {28'h0000000, s_q.status};
				A_IRQEN: s_d.rdata = {28'h0000000, s_q.irq_en};
				A_OUTS: s_d.rdata = {28'h0000000, s_q.out_n, s_q.out};
				default: s_d.rdata = '0;
			endcase
		end
		s_d.out = hit; // R12
		s_d.out_n = ~hit; // R13
		s_d.irq = |(s_d.status & s_d.irq_en);
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '0;
			s_q.on_pct <= {ON_RST, ON_RST}; // R8
			s_q.off_pct <= {OFF_RST, OFF_RST}; // R9
			s_q.rated <= RATED_RST;
			s_q.fmax <= FMAX_RST;
			s_q.poles <= POLES_RST;
			s_q.maxref <= MAXREF_RST;
			s_q.dv_busy <= 1'b1;
			s_q.dv_cnt <= DV_STEPS;
			s_q.dv_num <= DV_NUM_RST;
			s_q.dv_den <= DV_DEN_RST;
			s_q.out_n <= 2'h3; // R15
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata = s_q.rdata;
	assign cmp_out = s_q.out;
	assign cmp_out_n = s_q.out_n;
	assign irq = s_q.irq;

	sequence s_mode1_off;
		(s_q.mode[0] == 8'h00) [*3];
	endsequence

	property p_off_quiet;
		@(posedge core_clk) disable iff (!arst_n)
		s_mode1_off |-> !cmp_out[0] && cmp_out_n[0];
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("disabled comparator active"); // R2

	property p_inverse;
		@(posedge core_clk) disable iff (!arst_n)
		cmp_out == ~cmp_out_n;
	endproperty
	a_inverse: assert property (p_inverse) else $error("inverse output mismatch"); // R13

	property p_indep;
		@(posedge core_clk) disable iff (!arst_n)
		reg_wr && reg_addr == A_MODE1 |=> $stable(s_q.mode[1]) && $stable(s_q.on_pct[1]);
	endproperty
	a_indep: assert property (p_indep) else $error("channel two disturbed"); // R1

	property p_on_range;
		@(posedge core_clk) disable iff (!arst_n)
		reg_wr && reg_addr == A_ON1 |=> $signed(s_q.on_pct[0]) <= $signed(PCT_MAX[15:0])
			&& $signed(s_q.on_pct[0]) >= $signed(PCT_MIN[15:0]);
	endproperty
	a_on_range: assert property (p_on_range) else $error("on threshold out of range"); // R8

	property p_off_range;
		@(posedge core_clk) disable iff (!arst_n)
		reg_wr && reg_addr == A_OFF2 |=> $signed(s_q.off_pct[1]) <= $signed(PCT_MAX[15:0])
			&& $signed(s_q.off_pct[1]) >= $signed(PCT_MIN[15:0]);
	endproperty
	a_off_range: assert property (p_off_range) else $error("off threshold out of range"); // R9

	property p_dc_ref;
		@(posedge core_clk) disable iff (!arst_n)
		dec[0].base == B_DCLINK |-> ch[0].ref_val == DC_REF && ch[0].actual == dc_link_voltage;
	endproperty
	a_dc_ref: assert property (p_dc_ref) else $error("dc link reference wrong"); // R4

	property p_signed_mode;
		@(posedge core_clk) disable iff (!arst_n)
		s_q.mode[1] == 8'h6F |-> ch[1].signed_cmp && dec[1].base == B_FILT_CUR;
	endproperty
	a_signed_mode: assert property (p_signed_mode) else $error("signed mode not decoded"); // R6

	property p_speed_div;
		@(posedge core_clk) disable iff (!arst_n)
		!s_q.dv_busy |-> 32'(s_q.spd_ref) * 32'(s_q.poles) * 32'd5 <= 32'(s_q.fmax) * 32'd3
			&& 32'(s_q.fmax) * 32'd3 < (32'(s_q.spd_ref) + 32'd1) * 32'(s_q.poles) * 32'd5;
	endproperty
	a_speed_div: assert property (p_speed_div) else $error("speed reference wrong"); // R5

	property p_out_follow;
		@(posedge core_clk) disable iff (!arst_n)
		ch[0].rise |=> cmp_out[0] ##1 (cmp_out[0] == $past(ch[0].hit));
	endproperty
	a_out_follow: assert property (p_out_follow) else $error("output lost result"); // R12
endmodule

//--- test/test_dual_hysteresis_comparator.sv
// Self-checking bench for the dual hysteresis comparator top.
// Assumes dhc_pkg and the design files are compiled first; drives every port itself.
`timescale 1ns/100ps
module test_dual_hysteresis_comparator;
	import dhc_pkg::*;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic signed [15:0] q [14];
	logic [1:0] cmp_out;
	logic [1:0] cmp_out_n;
	logic irq;
	int n_fail = 0;
	int checked = 0;
	int seed = 32'h7b57;
	logic [31:0] rv;
	logic st;
	int m, b, r, x, idx;
	logic [7:0] ra [14] = '{A_MODE1, A_ON1, A_OFF1, A_ON2, A_OFF2, A_RATED, A_FMAX, A_POLES,
		A_MAXREF, A_SPDREF, A_STATUS, A_IRQEN, A_OUTS, 8'hFC};
	logic [31:0] rx [14] = '{32'h0, 32'h2710, 32'h1388, 32'h2710, 32'h1388, 32'h3E8, 32'h1388,
		32'h2, 32'h2710, 32'h5DC, 32'h0, 32'h0, 32'hC, 32'h0};
	int modes [28] = '{1, 2, 3, 4, 5, 6, 7, 9, 10, 11, 12, 13, 14, 15, 100, 101, 102, 103, 104,
		105, 106, 107, 111, 112, 8, 108, 113, 16};
	int xs2 [4] = '{-499, -600, -801, -700};

	always #12.5 core_clk = ~core_clk;

	initial begin
		foreach (q[j]) q[j] = 16'sh0000;
	end

	dhc_top dhc_top_i (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.rms_current(q[0]), .active_current(q[1]), .stator_freq(q[2]), .actual_speed(q[3]),
		.repetition_freq(q[4]), .winding_temp(q[5]), .actual_freq(q[6]),
		.dc_link_voltage(q[7]), .isq_current(q[8]), .filt_active_current(q[9]),
		.int_ref_freq(q[10]), .ref_percent(q[11]), .actual_percent(q[12]),
		.analog_input_one(q[13]), .cmp_out(cmp_out), .cmp_out_n(cmp_out_n), .irq(irq));

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	// data stand only in the cycle after the strobe, so sample just after that edge
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		rd(a, rv);
		chk("register", exp, rv);
	endtask

	// input change needs two edges to reach cmp_out; one spare
	task automatic chk_out(input int ch, input logic exp);
		repeat (3) @(posedge core_clk);
		#1;
		chk("cmp_out", {31'h0, exp}, {31'h0, cmp_out[ch]});
		chk("cmp_out_n", {31'h0, ~exp}, {31'h0, cmp_out_n[ch]});
	endtask

	function automatic int ref_of(input int bm);
		case (bm)
			1, 2, 10, 11: return 1000;
			3, 5, 7, 12: return 5000;
			4: return 1500;
			6: return 100;
			9: return 1000;
			default: return 10000;
		endcase
	endfunction

	function automatic bit legal(input int mm);
		return (mm >= 1 && mm <= 15 && mm != 8) || (mm >= 101 && mm <= 107) || mm == 111
			|| mm == 112;
	endfunction

	function automatic logic hyst(input logic prev, input longint v, input longint on,
		input longint off, input longint rr);
		if (v * 10000 > on * rr) return 1'b1;
		if (v * 10000 < off * rr) return 1'b0;
		return prev;
	endfunction

	initial begin
		#(25 * 20000);
		n_fail++;
		report_and_stop();
	end

	initial begin
		repeat (6) @(posedge core_clk);
		arst_n <= 1'b1;
		#1;
		chk("cmp_out reset", 32'h1, {30'h0, cmp_out_n, cmp_out} == 4'hC);
		chk("irq reset", 32'h0, {31'h0, irq});
		// let the speed divider finish its post-reset run
		repeat (25) @(posedge core_clk);
		foreach (ra[i]) rd_chk(ra[i], rx[i]);
		wr(A_ON1, 32'd40000);
		rd_chk(A_ON1, 32'h7530);
		wr(A_OFF1, -32'sd40000);
		rd_chk(A_OFF1, 32'hFFFF8AD0);
		wr(A_ON1, 32'd8000);
		wr(A_OFF1, 32'd5000);
		foreach (modes[i]) begin
			m = modes[i];
			b = (m >= 100) ? m - 100 : m;
			r = ref_of(b);
			@(posedge core_clk);
			foreach (q[j]) q[j] <= 16'sh0000;
			wr(A_MODE1, m);
			st = 1'b0;
			for (int k = 0; k < 8; k++) begin
				x = $random(seed) % (3 * r);
				// corners: just above on, negative with magnitude just above off, exactly at off
				if (k == 0) x = r * 4 / 5 + 1;
				if (k == 1) x = -(r / 2) - 1;
				if (k == 2) x = r / 2;
				idx = legal(m) ? ((b < 8) ? b - 1 : b - 2) : 6;
				@(posedge core_clk);
				foreach (q[j]) q[j] <= (j == idx) ? 16'(x) : 16'($random(seed));
				st = legal(m) ? hyst(st, (m >= 100 || x >= 0) ? x : -x, 8000, 5000, r) : 1'b0;
				chk_out(0, st);
				chk("channel two idle", 32'h0, {31'h0, cmp_out[1]});
			end
		end
		@(posedge core_clk);
		q[9] <= -16'sd900;
		wr(A_ON2, -32'sd5000);
		wr(A_OFF2, -32'sd8000);
		wr(A_MODE2, 32'd111);
		st = 1'b0;
		foreach (xs2[i]) begin
			@(posedge core_clk);
			q[9] <= 16'(xs2[i]);
			st = hyst(st, xs2[i], -5000, -8000, 1000);
			chk_out(1, st);
		end
		@(posedge core_clk);
		q[6] <= 16'sh0000;
		wr(A_MODE1, 32'd7);
		wr(A_CLEAR, 32'hF);
		wr(A_IRQEN, 32'h1);
		@(posedge core_clk);
		q[6] <= 16'sd4001;
		chk_out(0, 1'b1);
		chk("irq", 32'h1, {31'h0, irq});
		rd_chk(A_STATUS, 32'h1);
		wr(A_CLEAR, 32'h1);
		repeat (2) @(posedge core_clk);
		#1;
		chk("irq cleared", 32'h0, {31'h0, irq});
		wr(A_IRQEN, 32'h0);
		@(posedge core_clk);
		q[6] <= 16'sd2499;
		chk_out(0, 1'b0);
		chk("irq masked", 32'h0, {31'h0, irq});
		rd_chk(A_STATUS, 32'h2);
		wr(A_IRQEN, 32'h2);
		repeat (2) @(posedge core_clk);
		#1;
		chk("irq enabled", 32'h1, {31'h0, irq});
		// read-only place must ignore the write
		wr(A_OUTS, 32'hF);
		rd_chk(A_OUTS, 32'hC);
		wr(A_FMAX, 32'd6000);
		wr(A_POLES, 32'h0);
		rd(A_SPDREF, rv);
		chk("speed busy", 32'h1, {31'h0, rv[16]});
		rd_chk(A_POLES, 32'h1);
		repeat (25) @(posedge core_clk);
		rd_chk(A_SPDREF, 32'd3600);
		report_and_stop();
	end
endmodule
